// ==== csdf_defines.svh ====
// Constants for the signed-digit coefficient filter control block.
// How it works
// - Nibble is sign bit over three-bit shift.
// - Sign bit zero positive, one negative.
// - Shift code is plain unsigned count.
// - Later shifts add to preceding absolute shift.
// - Tap is nested signed power product.
// - Index one nibble is most significant.
// - Four nibbles per tap, three for FIR.
// - Transmit gain coefficient is one plus value.
// - Balance taps programmed or adapted; FIR only.
// - Adapt then hold; resume when error exceeds threshold.
// - Adapted FIR taps readable by host.
// - Near-end signal suspends adaptive iteration.
// - Iterate until error meets threshold.
// - Slot loopback routes PCM receive to transmit.
// - Scaling value 10000 loops converters digitally.
// - Looped signal still drives analog output.
// - Analog loopback through impedance filter.
// - Transmit high-pass filter can be bypassed.
// - Receive and transmit paths can be cut.
`ifndef CSDF_DEFINES_SVH
`define CSDF_DEFINES_SVH
`define CSDF_NIB_W 4
`define CSDF_SIGN_BIT 3
`define CSDF_SHIFT_W 3
`define CSDF_SUM_W 5
`define CSDF_VAL_W 24
`define CSDF_FRAC 14
`define CSDF_MAX_NIB 4
`define CSDF_FIR_NIB 3
`define CSDF_FIR_TAPS 8
`define CSDF_TAP_IDX_W 3
`define CSDF_SIG_W 16
`define CSDF_LOOP_SCALE 5'h10
`define CSDF_STEP_SHIFT 8
`endif

// ==== csdf_pkg.sv ====
// Types shared by the signed-digit coefficient filter control block.
package csdf_pkg;
   typedef enum logic [1:0] {
      CSDF_IDLE = 2'b00,
      CSDF_ITER = 2'b01,
      CSDF_HOLD = 2'b10
   } csdf_state_e;
   typedef logic [3:0] csdf_nib_t;
endpackage : csdf_pkg

// ==== csdf_decode.sv ====
// Combinational decoder from up to four signed-digit nibbles to a tap value.
`timescale 1ns/100ps
`include "csdf_defines.svh"
module csdf_decode
   import csdf_pkg::*;
(
   input wire logic [15:0] nibbles,
   input wire logic [2:0] count,
   input wire logic gain_offset,
   output logic signed [23:0] value
);
   logic signed [23:0] term [0:3];
   logic [4:0] sum [0:3];
   logic neg [0:3];
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_term
         wire [3:0] nib = nibbles[g*4 +: 4];
         wire [4:0] prev_sum;
         wire prev_neg;
         if (g == 0) begin : g_first
            assign prev_sum = 5'h00;
            assign prev_neg = 1'b0;
         end else begin : g_next
            assign prev_sum = sum[g-1];
            assign prev_neg = neg[g-1];
         end
         // five-bit running sum holds up to 28 without wrap.
         assign sum[g] = prev_sum + {2'b00, nib[2:0]};
         // signs multiply cumulatively down the nest.
         assign neg[g] = prev_neg ^ nib[`CSDF_SIGN_BIT];
         wire signed [23:0] mag = 24'sh004000 >>> sum[g];
         assign term[g] = (g < count) ? (neg[g] ? -mag : mag) : 24'sh000000;
      end
   endgenerate
   // transmit gain adds a unit term.
   assign value = term[0] + term[1] + term[2] + term[3]
                  + (gain_offset ? 24'sh004000 : 24'sh000000);
endmodule : csdf_decode

// ==== csdf_tap_mem.sv ====
// Small tap memory for the balance FIR section with registered read data.
`timescale 1ns/100ps
`include "csdf_defines.svh"
module csdf_tap_mem
   import csdf_pkg::*;
(
   input wire logic mclk,
   input wire logic wr_en,
   input wire logic [2:0] wr_addr,
   input wire logic signed [23:0] wr_data,
   input wire logic [2:0] rd_addr,
   output logic signed [23:0] rd_data
);
   logic signed [23:0] mem [0:`CSDF_FIR_TAPS-1];
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : csdf_tap_mem

// ==== csdf_filter_ctrl.sv ====
// Coefficient decode, adaptive balance control and test loopback routing.
`timescale 1ns/100ps
`include "csdf_defines.svh"
module csdf_filter_ctrl
   import csdf_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic coef_wr,
   input wire logic [15:0] coef_nibbles,
   input wire logic [2:0] coef_count,
   input wire logic gain_offset,
   output logic signed [23:0] coef_value,
   input wire logic fir_wr,
   input wire logic [2:0] fir_addr,
   input wire logic [11:0] fir_nibbles,
   input wire logic fir_rd,
   output logic signed [23:0] fir_rd_data,
   output logic fir_rd_valid,
   input wire logic adapt_enable,
   input wire logic [15:0] echo_path_gain,
   input wire logic [15:0] error_level_threshold,
   input wire logic signed [15:0] rx_sample,
   input wire logic signed [15:0] tx_sample,
   input wire logic sample_strobe,
   output logic adapt_active,
   output logic adapt_converged,
   input wire logic tsa_loopback,
   input wire logic [4:0] analog_impedance_scaling,
   input wire logic analog_loopback,
   input wire logic hpf_bypass,
   input wire logic rx_cut,
   input wire logic tx_cut,
   input wire logic signed [15:0] pcm_receive_input,
   input wire logic signed [15:0] adc_sample,
   input wire logic signed [15:0] tx_path_sample,
   input wire logic signed [15:0] tx_hpf_sample,
   input wire logic signed [15:0] rx_path_sample,
   input wire logic signed [15:0] z_filter_sample,
   output logic signed [15:0] pcm_transmit_output,
   output logic signed [15:0] dac_sample,
   output logic signed [15:0] analog_output,
   output logic signed [15:0] converter_input,
   output logic scaling_enable
);
   csdf_state_e state;
   csdf_state_e next_state;
   logic signed [23:0] dec_value;
   logic signed [23:0] fir_dec_value;
   logic [2:0] adapt_idx;
   logic signed [23:0] mem_rd;
   logic rd_pending;
   logic adapt_wr;
   logic signed [23:0] tap_update;
   logic [15:0] err_mag;
   logic [15:0] rx_mag;
   logic [31:0] echo_est;
   logic near_end;
   logic err_met;
   logic mem_wr;
   logic [2:0] mem_addr;
   logic signed [23:0] mem_wdata;
   logic signed [23:0] step;
   logic tap_fresh;
   logic [2:0] mem_wr_addr;
   csdf_decode u_gen_dec (
      .nibbles(coef_nibbles),
      .count(coef_count),
      .gain_offset(gain_offset),
      .value(dec_value)
   );
   csdf_decode u_fir_dec (
      .nibbles({4'h0, fir_nibbles}),
      .count(3'h3),
      .gain_offset(1'b0),
      .value(fir_dec_value)
   );
   always_ff @(posedge mclk) begin
      if (rst) begin
         coef_value <= 24'sh000000;
      end else if (coef_wr) begin
         coef_value <= dec_value;
      end
   end
   // Absolute values for the error and double-talk tests.
   function automatic logic [15:0] abs16(input logic signed [15:0] v);
      abs16 = v[15] ? 16'(-v) : 16'(v);
   endfunction : abs16
   assign err_mag = abs16(tx_sample);
   assign rx_mag = abs16(rx_sample);
   assign echo_est = rx_mag * echo_path_gain;
   // transmit level above predicted echo means near-end talker.
   assign near_end = {err_mag, 16'h0000} > echo_est;
   assign err_met = err_mag <= error_level_threshold;
   always_comb begin
      next_state = state;
      case (state)
         CSDF_IDLE: begin
            if (adapt_enable) begin
               next_state = CSDF_ITER;
            end
         end
         CSDF_ITER: begin
            if (!adapt_enable) begin
               next_state = CSDF_IDLE;
            end else if (sample_strobe && err_met) begin
               next_state = CSDF_HOLD;
            end
         end
         CSDF_HOLD: begin
            if (!adapt_enable) begin
               next_state = CSDF_IDLE;
            end else if (sample_strobe && !err_met) begin
               next_state = CSDF_ITER;
            end
         end
         default: begin
            next_state = CSDF_IDLE;
         end
      endcase
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= CSDF_IDLE;
      end else begin
         state <= next_state;
      end
   end
   // adaptation refines the host-seeded FIR taps one per sample.
   assign adapt_wr = (state == CSDF_ITER) && sample_strobe && !near_end && !err_met
                     && adapt_enable && !fir_wr && tap_fresh;
   // Sign-sign step toward the correlation of error with received signal.
   assign step = 24'sh000001 <<< `CSDF_STEP_SHIFT;
   assign tap_update = (tx_sample[15] ^ rx_sample[15]) ? mem_rd - step : mem_rd + step;
   assign mem_wr = fir_wr || adapt_wr;
   assign mem_addr = fir_wr ? fir_addr : (fir_rd ? fir_addr : adapt_idx);
   assign mem_wdata = fir_wr ? fir_dec_value : tap_update;
   assign mem_wr_addr = fir_wr ? fir_addr : adapt_idx;
   csdf_tap_mem u_taps (
      .mclk(mclk),
      .wr_en(mem_wr),
      .wr_addr(mem_wr_addr),
      .wr_data(mem_wdata),
      .rd_addr(mem_addr),
      .rd_data(mem_rd)
   );
   // The registered read data only hold the current adaptation tap when the last
   // edge neither wrote the memory nor read another address for the host.
   always_ff @(posedge mclk) begin
      if (rst) begin
         tap_fresh <= 1'b0;
      end else begin
         tap_fresh <= !(mem_wr || fir_rd);
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         adapt_idx <= 3'h0;
      end else if (adapt_wr) begin
         adapt_idx <= adapt_idx + 3'h1;
      end
   end
   // read-back of the adapted taps, two cycles after the request.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_pending <= 1'b0;
      end else begin
         rd_pending <= fir_rd && !fir_wr;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         fir_rd_data <= 24'sh000000;
         fir_rd_valid <= 1'b0;
      end else begin
         fir_rd_valid <= rd_pending;
         if (rd_pending) begin
            fir_rd_data <= mem_rd;
         end
      end
   end
   assign adapt_active = (state == CSDF_ITER);
   assign adapt_converged = (state == CSDF_HOLD);
   // Test paths.
   logic conv_loop;
   logic signed [15:0] tx_sel;
   logic signed [15:0] rx_sel;
   logic signed [15:0] next_pcm_tx;
   logic signed [15:0] next_analog_out;
   logic signed [15:0] next_conv_in;
   assign conv_loop = (analog_impedance_scaling == `CSDF_LOOP_SCALE);
   assign scaling_enable = !conv_loop;
   assign tx_sel = tx_cut ? 16'sh0000 : (hpf_bypass ? tx_path_sample : tx_hpf_sample);
   assign rx_sel = rx_cut ? 16'sh0000 : rx_path_sample;
   assign next_pcm_tx = tsa_loopback ? pcm_receive_input : tx_sel;
   assign next_analog_out = analog_loopback ? z_filter_sample : rx_sel;
   assign next_conv_in = conv_loop ? rx_sel : adc_sample;
   always_ff @(posedge mclk) begin
      if (rst) begin
         pcm_transmit_output <= 16'sh0000;
         dac_sample <= 16'sh0000;
         analog_output <= 16'sh0000;
         converter_input <= 16'sh0000;
      end else begin
         pcm_transmit_output <= next_pcm_tx;
         dac_sample <= rx_sel;
         analog_output <= next_analog_out;
         converter_input <= next_conv_in;
      end
   end
   a_tsa_loop: assert property (@(posedge mclk) disable iff (rst)
      tsa_loopback |=> pcm_transmit_output == $past(pcm_receive_input))
      else $error("slot loopback path wrong");
   a_conv_loop: assert property (@(posedge mclk) disable iff (rst)
      conv_loop && !analog_loopback |=> converter_input == analog_output)
      else $error("converter loopback wrong");
   a_tx_cut: assert property (@(posedge mclk) disable iff (rst)
      tx_cut && !tsa_loopback |=> pcm_transmit_output == 16'sh0000)
      else $error("transmit cut failed");
   a_hold_taps: assert property (@(posedge mclk) disable iff (rst)
      !adapt_enable && !fir_wr |-> !mem_wr)
      else $error("taps changed while disabled");
   a_near_end: assert property (@(posedge mclk) disable iff (rst)
      near_end && !fir_wr |-> !mem_wr)
      else $error("adapted during near-end talk");
   a_converge: assert property (@(posedge mclk) disable iff (rst)
      adapt_active && adapt_enable && sample_strobe && err_met |=> adapt_converged)
      else $error("missed convergence");
   sequence s_read_req;
      fir_rd && !fir_wr;
   endsequence
   a_read_back: assert property (@(posedge mclk) disable iff (rst)
      s_read_req |=> ##1 fir_rd_valid)
      else $error("read-back not answered");
   sequence s_no_request;
      !fir_rd || fir_wr;
   endsequence
   a_no_read_valid: assert property (@(posedge mclk) disable iff (rst)
      s_no_request |=> ##1 !fir_rd_valid)
      else $error("read-back without request");
   a_scaling_off: assert property (@(posedge mclk) disable iff (rst)
      scaling_enable == (analog_impedance_scaling != 5'h10))
      else $error("scaling enable wrong");
   a_enable_start: assert property (@(posedge mclk) disable iff (rst)
      state == CSDF_IDLE && adapt_enable |=> adapt_active)
      else $error("adaptation did not start");
   // Decoder spot checks on single-nibble and empty taps.
   a_first_unit: assert property (@(posedge mclk) disable iff (rst)
      coef_wr && coef_count == 3'h1 && coef_nibbles[3:0] == 4'h0 && !gain_offset
      |=> coef_value == 24'sh004000)
      else $error("unit nibble decoded wrong");
   a_neg_sign: assert property (@(posedge mclk) disable iff (rst)
      coef_wr && coef_count == 3'h1 && coef_nibbles[3:0] == 4'h8 && !gain_offset
      |=> coef_value == 24'shFFC000)
      else $error("negative nibble decoded wrong");
   a_unit_gain: assert property (@(posedge mclk) disable iff (rst)
      coef_wr && coef_count == 3'h0 && gain_offset |=> coef_value == 24'sh004000)
      else $error("gain offset missing");
   // Adaptation sequencing and tap update.
   sequence s_iter_strobe;
      adapt_active && adapt_enable && sample_strobe;
   endsequence
   sequence s_hold_miss;
      adapt_converged && adapt_enable && sample_strobe && !err_met;
   endsequence
   a_disable_idle: assert property (@(posedge mclk) disable iff (rst)
      !adapt_enable |=> !adapt_active && !adapt_converged)
      else $error("adaptation ran while disabled");
   a_hold_reiter: assert property (@(posedge mclk) disable iff (rst)
      s_hold_miss |=> adapt_active)
      else $error("held taps did not resume");
   a_met_no_write: assert property (@(posedge mclk) disable iff (rst)
      s_iter_strobe ##0 err_met |-> !mem_wr || fir_wr)
      else $error("adapted after threshold met");
   a_adapt_write: assert property (@(posedge mclk) disable iff (rst)
      s_iter_strobe ##0 (!near_end && !err_met && !fir_wr && tap_fresh) |-> mem_wr)
      else $error("adaptation step skipped");
   a_step_index: assert property (@(posedge mclk) disable iff (rst)
      adapt_wr |=> adapt_idx == $past(adapt_idx) + 3'h1)
      else $error("tap index did not advance");
   a_idx_hold: assert property (@(posedge mclk) disable iff (rst)
      !adapt_wr |=> $stable(adapt_idx))
      else $error("tap index moved without update");
   // Test path routing.
   a_rx_cut: assert property (@(posedge mclk) disable iff (rst)
      rx_cut |=> dac_sample == 16'sh0000)
      else $error("receive cut failed");
   a_hpf_bypass: assert property (@(posedge mclk) disable iff (rst)
      hpf_bypass && !tx_cut && !tsa_loopback |=> pcm_transmit_output == $past(tx_path_sample))
      else $error("high-pass bypass wrong");
   a_pcm_normal: assert property (@(posedge mclk) disable iff (rst)
      !hpf_bypass && !tx_cut && !tsa_loopback |=> pcm_transmit_output == $past(tx_hpf_sample))
      else $error("transmit path wrong");
   a_analog_loop: assert property (@(posedge mclk) disable iff (rst)
      analog_loopback |=> analog_output == $past(z_filter_sample))
      else $error("analog loopback wrong");
   a_dac_drive: assert property (@(posedge mclk) disable iff (rst)
      conv_loop && !analog_loopback |=> analog_output == dac_sample)
      else $error("looped signal not on output");
   a_conv_normal: assert property (@(posedge mclk) disable iff (rst)
      !conv_loop |=> converter_input == $past(adc_sample))
      else $error("converter input wrong");
endmodule : csdf_filter_ctrl

// ==== csdf_host_model.sv ====
// Host model that programs coefficients and controls adaptation.
`timescale 1ns/100ps
module csdf_host_model (
   input wire logic mclk,
   output logic coef_wr,
   output logic [15:0] coef_nibbles,
   output logic [2:0] coef_count,
   output logic gain_offset,
   output logic fir_wr,
   output logic fir_rd,
   output logic [2:0] fir_addr,
   output logic [11:0] fir_nibbles,
   output logic adapt_enable
);
   initial begin
      {coef_wr, coef_nibbles, coef_count, gain_offset} = '0;
      {fir_wr, fir_rd, fir_addr, fir_nibbles, adapt_enable} = '0;
   end
   task automatic coef(input logic [15:0] n, input logic [2:0] c, input logic o);
      @(negedge mclk);
      {coef_wr, coef_nibbles, coef_count, gain_offset} <= {1'b1, n, c, o};
      @(negedge mclk);
      coef_wr <= 1'b0;
   endtask : coef
   // A write seeds a tap; a read asks for it back.
   task automatic fir(input logic w, input logic [2:0] a, input logic [11:0] n);
      @(negedge mclk);
      {fir_wr, fir_rd, fir_addr, fir_nibbles} <= {w, !w, a, n};
      @(negedge mclk);
      {fir_wr, fir_rd} <= 2'b00;
   endtask : fir
   task automatic adapt(input logic e);
      @(negedge mclk);
      adapt_enable <= e;
   endtask : adapt
endmodule : csdf_host_model

// ==== csdf_filter_ctrl_tb.sv ====
// Self-checking testbench for the coefficient filter control block.
`timescale 1ns/100ps
module csdf_filter_ctrl_tb;
   import csdf_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic coef_wr, gain_offset, fir_wr, fir_rd, adapt_enable, sample_strobe = 1'b0;
   logic [15:0] coef_nibbles, echo_path_gain = '0, error_level_threshold = 16'h0010;
   logic [2:0] coef_count, fir_addr;
   logic [11:0] fir_nibbles;
   logic signed [15:0] rx_sample = 16'sh07D0, tx_sample = 16'sh03E8;
   logic tsa_loopback = 1'b0, analog_loopback = 1'b0, hpf_bypass = 1'b0;
   logic rx_cut = 1'b0, tx_cut = 1'b0;
   logic [4:0] analog_impedance_scaling = 5'h01;
   logic signed [15:0] pcm_receive_input = 16'sh1234, adc_sample = 16'sh0E0E;
   logic signed [15:0] tx_path_sample = 16'sh0A0A, tx_hpf_sample = 16'sh0B0B;
   logic signed [15:0] rx_path_sample = 16'sh0C0C, z_filter_sample = 16'sh0D0D;
   logic signed [23:0] coef_value, fir_rd_data, tap;
   logic fir_rd_valid, adapt_active, adapt_converged, scaling_enable;
   logic signed [15:0] pcm_transmit_output, dac_sample, analog_output, converter_input;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   logic [19:0] rows [9] = '{{16'h0000, 3'd1, 1'b0}, {16'h0008, 3'd1, 1'b0},
      {16'h0021, 3'd2, 1'b0}, {16'h00A1, 3'd2, 1'b0}, {16'h8889, 3'd4, 1'b0},
      {16'h0077, 3'd2, 1'b0}, {16'h0003, 3'd1, 1'b1}, {16'hFFF1, 3'd1, 1'b0},
      {16'h0000, 3'd0, 1'b1}};
   csdf_host_model host (.mclk(mclk), .coef_wr(coef_wr), .coef_nibbles(coef_nibbles),
      .coef_count(coef_count), .gain_offset(gain_offset), .fir_wr(fir_wr),
      .fir_rd(fir_rd), .fir_addr(fir_addr), .fir_nibbles(fir_nibbles),
      .adapt_enable(adapt_enable));
   csdf_filter_ctrl dut (.mclk(mclk), .rst(rst), .coef_wr(coef_wr),
      .coef_nibbles(coef_nibbles), .coef_count(coef_count), .gain_offset(gain_offset),
      .coef_value(coef_value), .fir_wr(fir_wr), .fir_addr(fir_addr),
      .fir_nibbles(fir_nibbles), .fir_rd(fir_rd), .fir_rd_data(fir_rd_data),
      .fir_rd_valid(fir_rd_valid), .adapt_enable(adapt_enable),
      .echo_path_gain(echo_path_gain), .error_level_threshold(error_level_threshold),
      .rx_sample(rx_sample), .tx_sample(tx_sample), .sample_strobe(sample_strobe),
      .adapt_active(adapt_active), .adapt_converged(adapt_converged),
      .tsa_loopback(tsa_loopback), .analog_impedance_scaling(analog_impedance_scaling),
      .analog_loopback(analog_loopback), .hpf_bypass(hpf_bypass), .rx_cut(rx_cut),
      .tx_cut(tx_cut), .pcm_receive_input(pcm_receive_input), .adc_sample(adc_sample),
      .tx_path_sample(tx_path_sample), .tx_hpf_sample(tx_hpf_sample),
      .rx_path_sample(rx_path_sample), .z_filter_sample(z_filter_sample),
      .pcm_transmit_output(pcm_transmit_output), .dac_sample(dac_sample),
      .analog_output(analog_output), .converter_input(converter_input),
      .scaling_enable(scaling_enable));
   initial begin
      forever #20 mclk = ~mclk;
   end
   // Signs multiply along the tap and shifts accumulate from the binary point.
   function automatic logic signed [23:0] ev(input logic [15:0] n, input int c, input logic o);
      int acc, s, m;
      acc = o ? 16384 : 0;
      s = 1;
      m = 0;
      for (int k = 0; k < c; k++) begin
         s = n[4*k+3] ? -s : s;
         m += n[4*k +: 3];
         if (m <= 14) acc += s * (1 << (14 - m));
      end
      return acc[23:0];
   endfunction : ev
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic read_tap(input logic [2:0] a);
      host.fir(1'b0, a, 12'h000);
      for (int i = 0; i < 4 && fir_rd_valid !== 1'b1; i++) @(negedge mclk);
      chk(fir_rd_valid, 1'b1);
      tap = fir_rd_data;
   endtask : read_tap
   task automatic strobe();
      @(negedge mclk);
      sample_strobe <= 1'b1;
      @(negedge mclk);
      sample_strobe <= 1'b0;
      repeat (2) @(negedge mclk);
   endtask : strobe
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      chk(coef_value, 24'h0);
      chk(adapt_active, 1'b0);
      rst <= 1'b0;
      $display("reset test done");
      foreach (rows[i]) begin
         host.coef(rows[i][19:4], rows[i][3:1], rows[i][0]);
         chk(coef_value, ev(rows[i][19:4], rows[i][3:1], rows[i][0]));
      end
      $display("decode table test done");
      host.fir(1'b1, 3'd0, 12'h889);
      read_tap(3'd0);
      chk(tap, ev(16'h0889, 3, 1'b0));
      host.fir(1'b1, 3'd0, 12'h000);
      host.fir(1'b1, 3'd1, 12'h000);
      host.adapt(1'b1);
      strobe();
      chk(adapt_active, 1'b1);
      read_tap(3'd0);
      chk(tap, ev(16'h0000, 3, 1'b0));
      echo_path_gain <= 16'hFFFF;
      strobe();
      read_tap(3'd0);
      chk(tap, ev(16'h0000, 3, 1'b0) + 24'h000100);
      tx_sample <= 16'sh0005;
      strobe();
      chk(adapt_converged, 1'b1);
      tx_sample <= 16'sh03E8;
      strobe();
      chk(adapt_active, 1'b1);
      host.adapt(1'b0);
      strobe();
      chk(adapt_active, 1'b0);
      read_tap(3'd0);
      chk(tap, ev(16'h0000, 3, 1'b0) + 24'h000100);
      read_tap(3'd1);
      chk(tap, ev(16'h0000, 3, 1'b0));
      $display("adaptation test done");
      chk(pcm_transmit_output, 24'(16'h0B0B));
      chk(converter_input, 24'(16'h0E0E));
      chk(dac_sample, 24'(16'h0C0C));
      tsa_loopback <= 1'b1;
      repeat (3) @(negedge mclk);
      chk(pcm_transmit_output, 24'(16'h1234));
      {tsa_loopback, hpf_bypass} <= 2'b01;
      repeat (3) @(negedge mclk);
      chk(pcm_transmit_output, 24'(16'h0A0A));
      {hpf_bypass, tx_cut, rx_cut} <= 3'b011;
      repeat (3) @(negedge mclk);
      chk(pcm_transmit_output, 24'h0);
      chk(dac_sample, 24'h0);
      {tx_cut, rx_cut} <= 2'b00;
      analog_impedance_scaling <= 5'h10;
      repeat (4) @(negedge mclk);
      chk(scaling_enable, 1'b0);
      chk(converter_input, 24'(16'h0C0C));
      chk(analog_output, 24'(16'h0C0C));
      chk(dac_sample, 24'(16'h0C0C));
      analog_loopback <= 1'b1;
      analog_impedance_scaling <= 5'h01;
      repeat (3) @(negedge mclk);
      chk(scaling_enable, 1'b1);
      chk(analog_output, 24'(16'h0D0D));
      $display("loopback test done");
      stop_test();
   end
endmodule : csdf_filter_ctrl_tb
